// file: inc/vcc_pkg.sv
// constants for the voltage comparator control block
// assumes a single 50 MHz core clock and a plain strobe register port
//
// Summary of operation
// - Control bit 10 enables the comparator; clearing it disables it.
// - Enabling the comparator raises an event; software clears it afterwards.
// - Bits 9-8 pick negative input: half supply, channel three, reference*0.6.
// - Bits 7-6 route output: 00/01 off, 10 logic array, 11 interrupt.
// - Bit 5 clear: high when positive above negative; set: inverted.
// - Bits 4-3 pick speed: 00 slow, 11 fast, 01 and 10 reserved.
// - Positive input shares channel two pin through a multiplexer.
// - Output feeds interrupt, logic array, conversion trigger and a pin.
// - Control register is 16 bits; bits 15-11 reserved.
// - Bit 2 switches the comparator hysteresis on or off.
// - Bit 1 set on rising edge of output; cleared by writing one.
// - Bit 0 set on falling edge of output; cleared by software.
package vcc_pkg;
	localparam int            ADDR_W       = 8;
	localparam int            DATA_W       = 16;
	// register offsets (byte addresses)
	localparam logic [7:0]    OFF_CTRL     = 8'h00;
	localparam logic [7:0]    OFF_MASK     = 8'h04;
	localparam logic [7:0]    OFF_STAT     = 8'h08;
	// control field positions
	localparam int            BIT_EN       = 10;
	localparam int            BIT_NSEL_HI  = 9;
	localparam int            BIT_NSEL_LO  = 8;
	localparam int            BIT_ROUTE_HI = 7;
	localparam int            BIT_ROUTE_LO = 6;
	localparam int            BIT_POL      = 5;
	localparam int            BIT_RESP_HI  = 4;
	localparam int            BIT_RESP_LO  = 3;
	localparam int            BIT_HYST     = 2;
	localparam int            BIT_RISE     = 1;
	localparam int            BIT_FALL     = 0;
	// status register positions
	localparam int            BIT_ST_LVL   = 0;
	localparam int            BIT_ST_EN    = 1;
	// codes
	localparam logic [1:0]    NSEL_HALF    = 2'h0;
	localparam logic [1:0]    NSEL_CH3     = 2'h1;
	localparam logic [1:0]    NSEL_REF     = 2'h2;
	localparam logic [1:0]    NSEL_RSV     = 2'h3;
	localparam logic [1:0]    ROUTE_OFF0   = 2'h0;
	localparam logic [1:0]    ROUTE_OFF1   = 2'h1;
	localparam logic [1:0]    ROUTE_PLA    = 2'h2;
	localparam logic [1:0]    ROUTE_IRQ    = 2'h3;
	localparam logic [1:0]    RESP_SLOW    = 2'h0;
	localparam logic [1:0]    RESP_FAST    = 2'h3;
	// reset values
	localparam logic [15:0]   RST_CTRL     = 16'h0000;
	localparam logic [1:0]    RST_MASK     = 2'h0;
endpackage

// file: core/vcc_sync3.sv
// three-stage synchroniser for an asynchronous level
// assumes clk_sys domain; output changes once stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module vcc_sync3 (
	// clock, reset, enable
	input  wire logic clk_sys,
	input  wire logic rst_n,
	input  wire logic ce,
	// level in and out
	input  wire logic async_in,
	output logic      sync_out
);
	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
		logic lvl;
	} vcc_sync_s;

	vcc_sync_s st_r;
	vcc_sync_s st_nxt;

	always_comb begin
		st_nxt    = st_r;
		st_nxt.s1 = async_in;
		st_nxt.s2 = st_r.s1;
		st_nxt.s3 = st_r.s2;
		// accept only a level that two stages agree on
		if (st_r.s2 == st_r.s3) begin
			st_nxt.lvl = st_r.s3;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			st_r <= '0;
		end else if (ce) begin
			st_r <= st_nxt;
		end
	end

	assign sync_out = st_r.lvl;
endmodule
`default_nettype wire

// file: core/vcc_ctrl.sv
// control, routing and edge-event logic around the voltage comparator
// assumes the analog comparator drives cmp_raw asynchronously
//
// Our own choices: the address map and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module vcc_ctrl (
	// clock, reset, enable
	input  wire logic        clk_sys,
	input  wire logic        nrst,
	input  wire logic        ce,
	// register port
	input  wire logic [7:0]  addr,
	input  wire logic [15:0] wr_data,
	input  wire logic        wr_en,
	input  wire logic        rd_en,
	output logic      [15:0] rd_data,
	// analog comparator side
	input  wire logic        cmp_raw,
	output logic             compare_enable,
	output logic             positive_input_connect,
	output logic      [1:0]  negative_input_select,
	output logic      [1:0]  response_speed_select,
	output logic             hysteresis_enable,
	// output destinations
	output logic             compare_output_pin,
	output logic             pla_out,
	output logic             irq_route_out,
	output logic             adc_trigger,
	output logic             irq
);
	typedef struct packed {
		logic        en;
		logic [1:0]  nsel;
		logic [1:0]  route;
		logic        pol;
		logic [1:0]  resp;
		logic        hyst;
		logic        rise_f;
		logic        fall_f;
		logic [1:0]  mask;
		logic        mon;
		logic        trig;
		logic [15:0] rdata;
	} vcc_state_s;

	vcc_state_s  st_r;
	vcc_state_s  st_nxt;
	logic        rst_m_r;
	logic        rst_n_s;
	logic        cmp_sync;
	logic        lvl;
	logic        rise_ev;
	logic        fall_ev;
	logic [15:0] ctrl_rd;
	logic [1:0]  w1c;
	logic        wr_ctrl;
	logic        wr_mask;
	logic        rd_unmap;

	function automatic logic hit(input logic [7:0] a,
		input logic [7:0] off);
		hit = (a == off);
	endfunction

	// reset release through two flops
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			rst_m_r <= 1'b0;
			rst_n_s <= 1'b0;
		end else begin
			rst_m_r <= 1'b1;
			rst_n_s <= rst_m_r;
		end
	end

	vcc_sync3 u_sync (
		.clk_sys  (clk_sys),
		.rst_n    (rst_n_s),
		.ce       (ce),
		.async_in (cmp_raw),
		.sync_out (cmp_sync)
	);

	// monitored level: polarity applied, forced low when off
	assign lvl     = st_r.en & (cmp_sync ^ st_r.pol);
	assign rise_ev = lvl & ~st_r.mon;
	assign fall_ev = st_r.en & ~lvl & st_r.mon;

	assign ctrl_rd = {5'h00, st_r.en, st_r.nsel, st_r.route, st_r.pol,
		st_r.resp, st_r.hyst, st_r.rise_f, st_r.fall_f};

	always_comb begin
		st_nxt     = st_r;
		w1c        = 2'h0;
		st_nxt.mon = lvl;
		st_nxt.trig = rise_ev;
		if (wr_en && hit(addr, vcc_pkg::OFF_CTRL)) begin
			st_nxt.en    = wr_data[vcc_pkg::BIT_EN];
			// reserved codes leave the field as it was
			if (wr_data[vcc_pkg::BIT_NSEL_HI:vcc_pkg::BIT_NSEL_LO]
				!= vcc_pkg::NSEL_RSV) begin
				st_nxt.nsel =
					wr_data[vcc_pkg::BIT_NSEL_HI:vcc_pkg::BIT_NSEL_LO];
			end
			st_nxt.route =
				wr_data[vcc_pkg::BIT_ROUTE_HI:vcc_pkg::BIT_ROUTE_LO];
			st_nxt.pol   = wr_data[vcc_pkg::BIT_POL];
			case (wr_data[vcc_pkg::BIT_RESP_HI:vcc_pkg::BIT_RESP_LO])
				vcc_pkg::RESP_SLOW,
				vcc_pkg::RESP_FAST: begin
					st_nxt.resp =
						wr_data[vcc_pkg::BIT_RESP_HI:vcc_pkg::BIT_RESP_LO];
				end
				default: begin
					st_nxt.resp = st_r.resp;
				end
			endcase
			st_nxt.hyst  = wr_data[vcc_pkg::BIT_HYST];
			w1c = {wr_data[vcc_pkg::BIT_RISE], wr_data[vcc_pkg::BIT_FALL]};
		end
		if (wr_en && hit(addr, vcc_pkg::OFF_MASK)) begin
			st_nxt.mask = wr_data[1:0];
		end
		// flags: set beats a same-cycle clear
		st_nxt.rise_f = rise_ev | (st_nxt.en & ~st_r.en)
			| (st_r.rise_f & ~w1c[1]);
		st_nxt.fall_f = fall_ev | (st_r.fall_f & ~w1c[0]);
		// read data stand one cycle only
		st_nxt.rdata = 16'h0000;
		if (rd_en) begin
			if (hit(addr, vcc_pkg::OFF_CTRL)) begin
				st_nxt.rdata = ctrl_rd;
			end else if (hit(addr, vcc_pkg::OFF_MASK)) begin
				st_nxt.rdata = {14'h0000, st_r.mask};
			end else if (hit(addr, vcc_pkg::OFF_STAT)) begin
				st_nxt.rdata = {14'h0000, st_r.en, st_r.mon};
			end else begin
				st_nxt.rdata = 16'h0000;
			end
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n_s) begin
		if (!rst_n_s) begin
			st_r        <= '0;
			st_r.en     <= vcc_pkg::RST_CTRL[vcc_pkg::BIT_EN];
			st_r.mask   <= vcc_pkg::RST_MASK;
		end else if (ce) begin
			st_r <= st_nxt;
		end
	end

	// analog controls
	assign compare_enable         = st_r.en;
	assign positive_input_connect = st_r.en;
	assign negative_input_select  = st_r.nsel;
	assign response_speed_select  = st_r.resp;
	assign hysteresis_enable      = st_r.hyst;

	// output destinations
	assign compare_output_pin = st_r.mon;
	assign pla_out       = st_r.mon & (st_r.route == vcc_pkg::ROUTE_PLA);
	assign irq_route_out = st_r.mon & (st_r.route == vcc_pkg::ROUTE_IRQ);
	assign adc_trigger   = st_r.trig;
	assign irq = (st_r.route == vcc_pkg::ROUTE_IRQ)
		& |({st_r.rise_f, st_r.fall_f} & st_r.mask);
	assign rd_data = st_r.rdata;

	// access decodes used by the checks below
	assign wr_ctrl  = ce & wr_en & hit(addr, vcc_pkg::OFF_CTRL);
	assign wr_mask  = ce & wr_en & hit(addr, vcc_pkg::OFF_MASK);
	assign rd_unmap = ce & rd_en & ~hit(addr, vcc_pkg::OFF_CTRL)
		& ~hit(addr, vcc_pkg::OFF_MASK) & ~hit(addr, vcc_pkg::OFF_STAT);

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n_s);

	ctrl_enable_a: assert property (
		(ce && wr_en && hit(addr, vcc_pkg::OFF_CTRL))
		|=> compare_enable == $past(wr_data[vcc_pkg::BIT_EN]))
		else $error("enable bit not taken from write");

	enable_event_a: assert property (
		$rose(st_r.en) |-> st_r.rise_f)
		else $error("enable did not raise the event flag");

	nsel_reserved_a: assert property (
		(ce && wr_en && hit(addr, vcc_pkg::OFF_CTRL)
		&& wr_data[9:8] == vcc_pkg::NSEL_RSV)
		|=> $stable(negative_input_select))
		else $error("reserved input code changed selection");

	route_pla_a: assert property (
		pla_out |-> (st_r.route == vcc_pkg::ROUTE_PLA) && compare_output_pin)
		else $error("logic array output with wrong route");

	polarity_a: assert property (
		ce |=> st_r.mon
		== ($past(st_r.en) & ($past(cmp_sync) ^ $past(st_r.pol))))
		else $error("monitored level wrong for polarity");

	resp_reserved_a: assert property (
		response_speed_select == vcc_pkg::RESP_SLOW
		|| response_speed_select == vcc_pkg::RESP_FAST)
		else $error("reserved response code stored");

	trigger_pulse_a: assert property (
		adc_trigger |-> compare_output_pin && !$past(compare_output_pin))
		else $error("trigger not on a rising edge");

	hyst_write_a: assert property (
		(ce && wr_en && hit(addr, vcc_pkg::OFF_CTRL))
		|=> hysteresis_enable == $past(wr_data[vcc_pkg::BIT_HYST]))
		else $error("hysteresis bit not taken");

	rise_flag_a: assert property (
		$rose(st_r.mon) |-> st_r.rise_f)
		else $error("rising edge lost");

	fall_flag_a: assert property (
		($fell(st_r.mon) && $past(st_r.en)) |-> st_r.fall_f)
		else $error("falling edge lost");

	off_quiet_a: assert property (
		(ce && !st_r.en) |=> !st_r.mon)
		else $error("level seen while disabled");

	read_ctrl_a: assert property (
		(ce && rd_en && hit(addr, vcc_pkg::OFF_CTRL))
		|=> rd_data[15:11] == 5'h00 && rd_data[10] == $past(st_r.en))
		else $error("control read wrong");

	connect_write_a: assert property (
		wr_ctrl |=> positive_input_connect == $past(wr_data[vcc_pkg::BIT_EN]))
		else $error("input connect not taken from write");

	nsel_write_a: assert property (
		(wr_ctrl && wr_data[9:8] != vcc_pkg::NSEL_RSV)
		|=> negative_input_select == $past(wr_data[9:8]))
		else $error("input select not taken from write");

	route_write_a: assert property (
		wr_ctrl |=> st_r.route == $past(wr_data[7:6]))
		else $error("route field not taken from write");

	pol_write_a: assert property (
		wr_ctrl |=> st_r.pol == $past(wr_data[vcc_pkg::BIT_POL]))
		else $error("polarity bit not taken from write");

	resp_write_a: assert property (
		(wr_ctrl && (wr_data[4:3] == vcc_pkg::RESP_SLOW
		|| wr_data[4:3] == vcc_pkg::RESP_FAST))
		|=> response_speed_select == $past(wr_data[4:3]))
		else $error("response code not taken from write");

	resp_keep_a: assert property (
		(wr_ctrl && wr_data[4:3] != vcc_pkg::RESP_SLOW
		&& wr_data[4:3] != vcc_pkg::RESP_FAST)
		|=> $stable(response_speed_select))
		else $error("reserved response code changed speed");

	route_irq_a: assert property (
		irq_route_out
		|-> (st_r.route == vcc_pkg::ROUTE_IRQ) && compare_output_pin)
		else $error("interrupt route output with wrong route");

	route_off_a: assert property (
		(st_r.route == vcc_pkg::ROUTE_OFF0 || st_r.route == vcc_pkg::ROUTE_OFF1)
		|-> !pla_out && !irq_route_out && !irq)
		else $error("output routed while connections off");

	irq_gate_a: assert property (
		irq |-> st_r.route == vcc_pkg::ROUTE_IRQ)
		else $error("interrupt raised without interrupt route");

	irq_raise_a: assert property (
		(st_r.route == vcc_pkg::ROUTE_IRQ && st_r.rise_f && st_r.mask[1])
		|-> irq)
		else $error("unmasked rise flag gave no interrupt");

	irq_fall_a: assert property (
		(st_r.route == vcc_pkg::ROUTE_IRQ && st_r.fall_f && st_r.mask[0])
		|-> irq)
		else $error("unmasked fall flag gave no interrupt");

	rise_set_a: assert property (
		(ce && rise_ev) |=> st_r.rise_f && adc_trigger)
		else $error("rising edge did not set flag and trigger");

	fall_set_a: assert property (
		(ce && fall_ev) |=> st_r.fall_f)
		else $error("falling edge did not set flag");

	rise_clear_a: assert property (
		(wr_ctrl && wr_data[vcc_pkg::BIT_RISE] && !rise_ev
		&& !(wr_data[vcc_pkg::BIT_EN] && !st_r.en))
		|=> !st_r.rise_f)
		else $error("rise flag not cleared by writing one");

	fall_clear_a: assert property (
		(wr_ctrl && wr_data[vcc_pkg::BIT_FALL] && !fall_ev)
		|=> !st_r.fall_f)
		else $error("fall flag not cleared by writing one");

	rise_hold_a: assert property (
		(ce && st_r.rise_f && !(wr_ctrl && wr_data[vcc_pkg::BIT_RISE]))
		|=> st_r.rise_f)
		else $error("rise flag dropped without a clear");

	fall_hold_a: assert property (
		(ce && st_r.fall_f && !(wr_ctrl && wr_data[vcc_pkg::BIT_FALL]))
		|=> st_r.fall_f)
		else $error("fall flag dropped without a clear");

	off_events_a: assert property (
		!st_r.en |-> !rise_ev && !fall_ev)
		else $error("edge event while disabled");

	off_trigger_a: assert property (
		(ce && !st_r.en) |=> !adc_trigger)
		else $error("trigger while disabled");

	rd_idle_a: assert property (
		(ce && !rd_en) |=> rd_data == 16'h0000)
		else $error("read data outside the read cycle");

	rd_unmap_a: assert property (
		rd_unmap |=> rd_data == 16'h0000)
		else $error("unmapped read not zero");

	rd_mask_a: assert property (
		(ce && rd_en && hit(addr, vcc_pkg::OFF_MASK))
		|=> rd_data == {14'h0000, $past(st_r.mask)})
		else $error("mask read wrong");

	rd_status_a: assert property (
		(ce && rd_en && hit(addr, vcc_pkg::OFF_STAT))
		|=> rd_data[vcc_pkg::BIT_ST_EN] == $past(st_r.en)
		&& rd_data[vcc_pkg::BIT_ST_LVL] == $past(st_r.mon))
		else $error("status read wrong");

	mask_write_a: assert property (
		wr_mask |=> st_r.mask == $past(wr_data[1:0]))
		else $error("mask not taken from write");

	ce_freeze_a: assert property (
		!ce |=> $stable(st_r))
		else $error("state moved while clock enable low");

	enable_c: cover property ($rose(compare_enable));
	rise_c: cover property (st_r.en && $rose(st_r.mon));
	fall_c: cover property (st_r.en && $fell(st_r.mon));
	irq_c: cover property ($rose(irq));
	clear_c: cover property (wr_ctrl && wr_data[vcc_pkg::BIT_RISE] && st_r.rise_f);
endmodule
`default_nettype wire

// file: bench/vcc_cmp_model.sv
// analog comparator model, voltages in microvolts
// assumes the bench sets pos_uv and ch3_uv; output moves off the clock edge
`timescale 1ns/1ps
`default_nettype none
module vcc_cmp_model #(
	parameter int HALF_UV = 1650000,
	parameter int REF_UV  = 2500000,
	parameter int HYST_UV = 7500
) (
	// clock and controls
	input  wire logic       clk_sys,
	input  wire logic       en,
	input  wire logic [1:0] nsel,
	input  wire logic       hyst,
	// voltages
	input  var  int         pos_uv,
	input  var  int         ch3_uv,
	// raw output
	output logic            cmp_raw
);
	int neg;
	int hv;
	initial cmp_raw = 1'b0;
	always_comb begin
		hv = hyst ? HYST_UV : 0;
		case (nsel)
			2'h1: neg = ch3_uv;
			2'h2: neg = REF_UV * 6 / 10;
			default: neg = HALF_UV;
		endcase
	end
	// powered down: output wanders every cycle
	always @(negedge clk_sys) begin
		if (!en)
			cmp_raw <= ~cmp_raw;
		else if (pos_uv > neg + hv)
			cmp_raw <= 1'b1;
		else if (pos_uv < neg - hv)
			cmp_raw <= 1'b0;
	end
endmodule
`default_nettype wire

// file: bench/tb.sv
// self-checking bench for the comparator control block
// assumes vcc_cmp_model drives cmp_raw
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic        clk_sys = 1'b0;
	logic        nrst = 1'b1;
	logic        ce = 1'b1;
	logic [7:0]  addr = 8'h00;
	logic [15:0] wr_data = 16'h0000;
	logic        wr_en = 1'b0;
	logic        rd_en = 1'b0;
	logic [15:0] rd_data;
	logic        cmp_raw, en, pic, hyst, pin, programmable_logic_array, irq_r, trig, irq;
	logic [1:0]  nsel, resp;
	int          pos_uv = 0;
	int          ch3_uv = 1000000;
	int          fails = 0;
	int          checked = 0;
	int          trigs = 0;
	int          t0;
	logic [31:0] seed = 32'h2ebb_2f8a;
	logic [15:0] cur = 16'h0000;
	logic [15:0] w;

	vcc_ctrl dut (.clk_sys(clk_sys), .nrst(nrst), .ce(ce), .addr(addr),
		.wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
		.cmp_raw(cmp_raw), .compare_enable(en), .positive_input_connect(pic),
		.negative_input_select(nsel), .response_speed_select(resp),
		.hysteresis_enable(hyst), .compare_output_pin(pin), .pla_out(programmable_logic_array),
		.irq_route_out(irq_r), .adc_trigger(trig), .irq(irq));
	vcc_cmp_model cmp (.clk_sys(clk_sys), .en(en), .nsel(nsel), .hyst(hyst),
		.pos_uv(pos_uv), .ch3_uv(ch3_uv), .cmp_raw(cmp_raw));

	initial forever #10 clk_sys = ~clk_sys;
	always @(posedge clk_sys) if (trig === 1'b1) trigs++;

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	// reserved codes leave the old field in place
	function automatic logic [15:0] nxt(input logic [15:0] o,
		input logic [15:0] d);
		logic [15:0] r;
		r = d & 16'h07FC;
		if (d[9:8] == 2'h3) r[9:8] = o[9:8];
		if (d[4:3] == 2'h1 || d[4:3] == 2'h2) r[4:3] = o[4:3];
		return r;
	endfunction
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge clk_sys);
		addr <= a;
		wr_data <= d;
		wr_en <= 1'b1;
		@(posedge clk_sys);
		wr_en <= 1'b0;
	endtask
	task automatic wc(input logic [15:0] d);
		cur = nxt(cur, d);
		wr(vcc_pkg::OFF_CTRL, d);
	endtask
	task automatic cmpv(input string n, input logic [15:0] e,
		input logic [15:0] g);
		checked++;
		if (g !== e) begin
			fails++;
			$display("MISMATCH %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic chk(input string n, input logic [7:0] a, input logic [15:0] m,
		input logic [15:0] e);
		@(posedge clk_sys);
		addr <= a;
		rd_en <= 1'b1;
		@(posedge clk_sys);
		rd_en <= 1'b0;
		#1 cmpv(n, e, rd_data & m);
	endtask
	task automatic outs(input logic [4:0] e);
		repeat (6) @(posedge clk_sys);
		#1 cmpv("pin pla irqr irq trig", {11'h0, e},
			{11'h0, pin, programmable_logic_array, irq_r, irq, trig});
	endtask
	task automatic end_of_test;
		$display("checked %0d fails %0d", checked, fails);
		if (fails == 0 && checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	initial begin
		repeat (5000) @(posedge clk_sys);
		fails++;
		end_of_test;
	end
	initial begin
		nrst <= 1'b0;
		repeat (12) @(posedge clk_sys);
		nrst <= 1'b1;
		repeat (4) @(posedge clk_sys);
		chk("ctrl reset", vcc_pkg::OFF_CTRL, 16'hFFFF, vcc_pkg::RST_CTRL);
		chk("mask reset", vcc_pkg::OFF_MASK, 16'hFFFF, 16'h0000);
		chk("unmapped", 8'h0C, 16'hFFFF, 16'h0000);
		for (int i = 0; i < 24; i++) begin
			seed = lfsr(seed);
			w = seed[15:0];
			if (i < 4) w[9:3] = {i[1:0], i[1:0], 1'b0, i[1:0]};
			wc(w);
			chk("ctrl", vcc_pkg::OFF_CTRL, 16'hFFFC, cur);
			cmpv("nsel resp", {12'h0, cur[9:8], cur[4:3]},
				{12'h0, nsel, resp});
			cmpv("en hyst", {13'h0, cur[10], cur[10], cur[2]},
				{13'h0, en, pic, hyst});
		end
		$display("test registers done");
		wc(16'h0003);
		pos_uv = 0;
		repeat (10) @(posedge clk_sys);
		chk("off flags", vcc_pkg::OFF_CTRL, 16'h0003, 16'h0000);
		wr(vcc_pkg::OFF_MASK, 16'h0003);
		wc(16'h04C0);
		chk("enable flag", vcc_pkg::OFF_CTRL, 16'h0002, 16'h0002);
		outs(5'b00010);
		wr(vcc_pkg::OFF_MASK, 16'h0000);
		outs(5'b00000);
		wr(vcc_pkg::OFF_MASK, 16'h0003);
		wc(16'h04C3);
		outs(5'b00000);
		chk("cleared", vcc_pkg::OFF_CTRL, 16'h0003, 16'h0000);
		$display("test enable event done");
		t0 = trigs;
		pos_uv = 2000000;
		outs(5'b10110);
		cmpv("triggers", 16'(t0 + 1), 16'(trigs));
		chk("rise", vcc_pkg::OFF_CTRL, 16'h0003, 16'h0002);
		chk("status", vcc_pkg::OFF_STAT, 16'h0003, 16'h0003);
		pos_uv = 0;
		outs(5'b00010);
		chk("fall", vcc_pkg::OFF_CTRL, 16'h0003, 16'h0003);
		wc(16'h04A3);
		outs(5'b11000);
		$display("test edges done");
		wc(16'h0003);
		repeat (10) @(posedge clk_sys);
		chk("off quiet", vcc_pkg::OFF_CTRL, 16'h0003, 16'h0000);
		outs(5'b00000);
		@(posedge clk_sys);
		ce <= 1'b0;
		wr(vcc_pkg::OFF_CTRL, 16'h0400);
		ce <= 1'b1;
		chk("frozen", vcc_pkg::OFF_CTRL, 16'hFFFC, 16'h0000);
		$display("test disable done");
		end_of_test;
	end
endmodule
`default_nettype wire
